// File: src/hsp_defines.svh
/*
 * Constants of the host serial port steering block: queue depths, flow
 * thresholds and setting encodings. Included by the steering module; the
 * types live in hsp_pkg. Definitions only.
 */
`ifndef HSP_DEFINES_SVH
`define HSP_DEFINES_SVH

// =========================================================================
// queues
`define HSP_TXQ_DEPTH      4'h8
`define HSP_RXQ_DEPTH      7'h40

// =========================================================================
// flow control thresholds; CTS in free bytes of the receive queue, RTS slip in bytes
`define HSP_CTS_STOP_FREE  7'h11
`define HSP_CTS_GO_FREE    7'h22
`define HSP_RTS_SLIP_MAX   3'h5

// =========================================================================
// setting encodings
`define HSP_FRAME_TRANSPARENT 2'h0
`define HSP_SSEL_IDLE         1'h1

`endif

// File: src/hsp_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides and a fill level.
 * Assumes DEPTH is a power of two so the pointers wrap by themselves.
 */
`timescale 1ns/10ps
module hsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic                       clk_i,
	input  wire logic                       nrst_i,
	input  wire logic                       in_valid_i,
	output logic                            in_ready_o,
	input  wire logic [WIDTH-1:0]           in_data_i,
	output logic                            out_valid_o,
	input  wire logic                       out_ready_i,
	output logic [WIDTH-1:0]                out_data_o,
	output logic [$clog2(DEPTH+1)-1:0]      level_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
	logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
	logic [CW-1:0]    cnt_reg, cnt_next;
	logic             push;
	logic             pop;

	// =====================================================================
	// handshake: full and empty come straight from the count
	assign in_ready_o  = (cnt_reg != CW'(DEPTH));
	assign out_valid_o = (cnt_reg != {CW{1'b0}});
	assign out_data_o  = mem_reg[rd_ptr_reg];
	assign level_o     = cnt_reg;
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// pointer and count next values
	always_comb begin
		wr_ptr_next = push ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
		rd_ptr_next = pop ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
		cnt_next    = cnt_reg + CW'(push) - CW'(pop);
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			cnt_reg    <= {CW{1'b0}};
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			cnt_reg    <= cnt_next;
		end
	end

	// storage entries; data needs no reset, the count guards it
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge clk_i) begin
			if (push && (wr_ptr_reg == AW'(i))) begin
				mem_reg[i] <= in_data_i;
			end
		end
	end

endmodule

// File: src/hsp_pkg.sv
/*
 * Types shared by the host serial port steering block.
 * Assumes the defines header supplies all numeric constants.
 */
package hsp_pkg;

	// =====================================================================
	// port selection state
	typedef enum logic [1:0] {
		HSP_SEL_BOOT,
		HSP_SEL_OPEN,
		HSP_SEL_UART,
		HSP_SEL_SPI
	} hsp_sel_e;

	// =====================================================================
	// saved configuration as seen by the block
	typedef struct packed {
		logic [1:0] uart_pins;          // data-in, data-out set as peripherals
		logic [3:0] spi_pins;           // slave-out, slave-in, select, clock
		logic [1:0] frame_mode_setting; // 0 transparent, else framed
		logic       rts_enable_setting;
		logic       cts_enable_setting;
		logic       data_present_setting;
	} hsp_cfg_s;

	// raw SPI pins from the master
	typedef struct packed {
		logic sclk;
		logic mosi;
		logic ssel_n;
	} hsp_spi_pins_s;

endpackage

// File: src/hsp_steer.sv
/*
 * Host serial port steering: picks UART or SPI slave as the host port,
 * queues host data toward the radio and radio data toward the host,
 * applies RTS/CTS, data present and packetization decisions.
 * Assumes a byte-level UART sits on the same clock, SPI pins and RTS come
 * asynchronously from outside, and the radio side speaks valid/ready.
 */
`timescale 1ns/10ps
`include "hsp_defines.svh"
module hsp_steer (
	input  wire logic                  clk_i,
	input  wire logic                  nrst_i,
	// configuration and transparent-mode controls
	input  wire hsp_pkg::hsp_cfg_s     cfg_i,
	input  wire logic [7:0]            packetize_timeout_i,
	input  wire logic [7:0]            max_payload_count_i,
	input  wire logic                  char_tick_i,
	input  wire logic                  cmd_seq_seen_i,
	// byte-level UART
	input  wire logic                  uart_rx_valid_i,
	input  wire logic [7:0]            uart_rx_data_i,
	output logic                       uart_tx_valid_o,
	output logic [7:0]                 uart_tx_data_o,
	input  wire logic                  uart_tx_ready_i,
	input  wire logic                  rts_pin_i,
	output logic                       cts_pin_o,
	output logic                       data_present_line_n_o,
	// SPI slave pins
	input  wire hsp_pkg::hsp_spi_pins_s spi_pins_i,
	output logic                       spi_miso_o,
	output logic                       spi_miso_oe_o,
	output logic                       spi_attn_n_o,
	// radio side
	input  wire logic                  rf_rx_valid_i,
	input  wire logic                  rf_rx_first_i,
	input  wire logic [7:0]            rf_rx_len_i,
	input  wire logic [7:0]            rf_rx_data_i,
	output logic                       rf_rx_ready_o,
	output logic                       rf_rx_drop_o,
	output logic                       rf_tx_valid_o,
	output logic [7:0]                 rf_tx_data_o,
	input  wire logic                  rf_tx_ready_i,
	output logic                       packetize_o,
	output logic                       framed_o,
	output logic                       spi_active_o
);
	// =====================================================================
	// declarations
	hsp_pkg::hsp_sel_e sel_reg, sel_next;
	logic [2:0] sclk_sync_reg;
	logic [2:0] ssel_sync_reg;
	logic [1:0] mosi_sync_reg;
	logic [1:0] rts_sync_reg;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [7:0] rx_sr_reg, rx_sr_next;
	logic [7:0] tx_sr_reg, tx_sr_next;
	logic       spi_byte_reg, spi_byte_next;
	logic       tx_held_reg, tx_held_next;
	logic       rf_drop_reg, rf_drop_next;
	logic       drop_flag_reg, drop_flag_next;
	logic       cts_reg, cts_next;
	logic       dp_n_reg, dp_n_next;
	logic       attn_n_reg, attn_n_next;
	logic [7:0] since_reg, since_next;
	logic [7:0] idle_reg, idle_next;
	logic       pkt_reg, pkt_next;
	logic       uart_ok, spi_ok;
	logic       ssel_on, ssel_fall, spi_rise, spi_fall, spi_live;
	logic       uart_side, spi_side, spi_pop, uart_pop, rts_hold;
	logic       rxq_in_valid, rxq_in_ready, txq_in_valid, txq_in_ready;
	logic [7:0] rxq_in_data;
	logic       txq_out_valid, txq_out_ready;
	logic [7:0] txq_out_data;
	logic [6:0] rxq_level, rx_free;
	logic [3:0] txq_level, txq_free;
	logic       fits, drop_now, transparent, uart_push;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	// =====================================================================
	// pin synchronisers; stage 0 feeds stage 1 only, stage 2 is for edges
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			sclk_sync_reg <= 3'h0;
			ssel_sync_reg <= 3'h7;
			mosi_sync_reg <= 2'h0;
			rts_sync_reg  <= 2'h0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], spi_pins_i.sclk};
			ssel_sync_reg <= {ssel_sync_reg[1:0], spi_pins_i.ssel_n};
			mosi_sync_reg <= {mosi_sync_reg[0], spi_pins_i.mosi};
			rts_sync_reg  <= {rts_sync_reg[0], rts_pin_i};
		end
	end

	// =====================================================================
	// port selection
	// pin enables
	assign uart_ok = &cfg_i.uart_pins;
	assign spi_ok  = &cfg_i.spi_pins;
	assign ssel_on   = (ssel_sync_reg[1] != `HSP_SSEL_IDLE);
	assign ssel_fall = ssel_on & (ssel_sync_reg[2] == `HSP_SSEL_IDLE);

	// boot lasts one cycle so the configuration is read after reset release
	always_comb begin
		sel_next = sel_reg;
		case (sel_reg)
			hsp_pkg::HSP_SEL_BOOT: begin
				if (uart_ok && spi_ok) begin
					sel_next = hsp_pkg::HSP_SEL_OPEN;
				end else if (spi_ok) begin
					sel_next = hsp_pkg::HSP_SEL_SPI;
				end else begin
					sel_next = hsp_pkg::HSP_SEL_UART;
				end
			end
			hsp_pkg::HSP_SEL_OPEN: begin
				if (uart_rx_valid_i) begin
					sel_next = hsp_pkg::HSP_SEL_UART;
				end else if (ssel_on) begin
					sel_next = hsp_pkg::HSP_SEL_SPI;
				end
			end
			default: sel_next = sel_reg;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			sel_reg <= hsp_pkg::HSP_SEL_BOOT;
		end else begin
			sel_reg <= sel_next;
		end
	end

	assign uart_side    = (sel_reg == hsp_pkg::HSP_SEL_UART) | (sel_reg == hsp_pkg::HSP_SEL_OPEN);
	assign spi_side     = (sel_reg == hsp_pkg::HSP_SEL_SPI);
	assign spi_active_o = spi_side;

	a_sel_sticky: assert property ((sel_reg inside {hsp_pkg::HSP_SEL_UART, hsp_pkg::HSP_SEL_SPI})
		|=> $stable(sel_reg)) else $error("port choice changed without reset");
	a_boot_single: assert property ((sel_reg == hsp_pkg::HSP_SEL_BOOT) && spi_ok && !uart_ok
		|=> spi_side) else $error("SPI-only configuration did not select SPI");
	a_boot_uart: assert property ((sel_reg == hsp_pkg::HSP_SEL_BOOT) && !spi_ok
		|=> (sel_reg == hsp_pkg::HSP_SEL_UART)) else $error("fallback to UART missing");
	a_open_select: assert property ((sel_reg == hsp_pkg::HSP_SEL_OPEN) && ssel_on
		&& !uart_rx_valid_i |=> spi_side ##1 spi_side) else $error("select did not take SPI");

	// =====================================================================
	// SPI mode 0 shifter: sample on rise, shift out on fall, bit 7 first
	assign spi_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
	assign spi_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
	assign spi_live = ssel_on & (spi_side | (sel_reg == hsp_pkg::HSP_SEL_OPEN));

	always_comb begin
		bit_cnt_next  = bit_cnt_reg;
		rx_sr_next    = rx_sr_reg;
		tx_sr_next    = tx_sr_reg;
		spi_byte_next = 1'b0;
		spi_pop       = 1'b0;
		tx_held_next  = tx_held_reg;
		if (!spi_live) begin
			bit_cnt_next = 3'h0;
		end else begin
			if (spi_rise) begin
				rx_sr_next    = {rx_sr_reg[6:0], mosi_sync_reg[1]};
				bit_cnt_next  = bit_cnt_reg + 3'h1;
				spi_byte_next = (bit_cnt_reg == 3'h7);
				// a loaded byte leaves the queue only once its first bit is taken,
				// so a select dropped between bytes does not lose it
				spi_pop       = tx_held_reg & (bit_cnt_reg == 3'h0);
				tx_held_next  = tx_held_reg & (bit_cnt_reg != 3'h0);
			end
			if (ssel_fall || (spi_fall && (bit_cnt_reg == 3'h0))) begin
				tx_held_next = spi_side & txq_out_valid;
				tx_sr_next   = tx_held_next ? txq_out_data : 8'h00;
			end else if (spi_fall) begin
				tx_sr_next = {tx_sr_reg[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			bit_cnt_reg  <= 3'h0;
			rx_sr_reg    <= 8'h00;
			tx_sr_reg    <= 8'h00;
			spi_byte_reg <= 1'b0;
			tx_held_reg  <= 1'b0;
		end else begin
			bit_cnt_reg  <= bit_cnt_next;
			rx_sr_reg    <= rx_sr_next;
			tx_sr_reg    <= tx_sr_next;
			spi_byte_reg <= spi_byte_next;
			tx_held_reg  <= tx_held_next;
		end
	end

	// miso only driven while this slave is selected and SPI may be used
	assign spi_miso_o    = tx_sr_reg[7];
	assign spi_miso_oe_o = spi_live;

	a_spi_byte: assert property (spi_live && spi_rise && (bit_cnt_reg == 3'h7)
		|=> spi_byte_reg && (rx_sr_reg[0] == $past(mosi_sync_reg[1])))
		else $error("SPI byte not completed after eight rises");

	// =====================================================================
	// host to radio queue; a full queue drops the new byte
	// other port blocked
	assign rxq_in_valid = (uart_rx_valid_i & uart_side) | (spi_byte_reg & spi_side);
	assign rxq_in_data  = spi_side ? rx_sr_reg : uart_rx_data_i;
	assign uart_push    = uart_rx_valid_i & uart_side & rxq_in_ready;

	hsp_fifo #(
		.WIDTH (8),
		.DEPTH (`HSP_RXQ_DEPTH)
	) u_rxq (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (rxq_in_valid),
		.in_ready_o  (rxq_in_ready),
		.in_data_i   (rxq_in_data),
		.out_valid_o (rf_tx_valid_o),
		.out_ready_i (rf_tx_ready_i),
		.out_data_o  (rf_tx_data_o),
		.level_o     (rxq_level)
	);

	a_rx_overflow: assert property (rxq_in_valid && !rxq_in_ready
		|=> rxq_level <= $past(rxq_level)) else $error("byte written into full queue");

	// =====================================================================
	// radio to host queue with whole-packet admission
	assign txq_free = `HSP_TXQ_DEPTH - txq_level;
	assign fits     = ({4'h0, txq_free} >= rf_rx_len_i);
	assign drop_now      = rf_rx_first_i ? ~fits : rf_drop_reg;
	assign txq_in_valid  = rf_rx_valid_i & ~drop_now;
	assign rf_rx_ready_o = drop_now | txq_in_ready;

	// the decision taken on the first byte holds for the rest of the packet
	always_comb begin
		rf_drop_next   = rf_drop_reg;
		drop_flag_next = 1'b0;
		if (rf_rx_valid_i && rf_rx_first_i) begin
			rf_drop_next   = ~fits;
			drop_flag_next = ~fits;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rf_drop_reg   <= 1'b0;
			drop_flag_reg <= 1'b0;
		end else begin
			rf_drop_reg   <= rf_drop_next;
			drop_flag_reg <= drop_flag_next;
		end
	end
	assign rf_rx_drop_o = drop_flag_reg;

	hsp_fifo #(
		.WIDTH (8),
		.DEPTH (`HSP_TXQ_DEPTH)
	) u_txq (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (txq_in_valid),
		.in_ready_o  (txq_in_ready),
		.in_data_i   (rf_rx_data_i),
		.out_valid_o (txq_out_valid),
		.out_ready_i (txq_out_ready),
		.out_data_o  (txq_out_data),
		.level_o     (txq_level)
	);

	sequence s_big_first;
		rf_rx_valid_i && rf_rx_first_i && ({4'h0, txq_free} < rf_rx_len_i);
	endsequence
	sequence s_dropped;
		!txq_in_valid ##1 rf_rx_drop_o;
	endsequence
	a_pkt_drop: assert property (s_big_first |-> s_dropped)
		else $error("oversized packet not dropped whole");

	// =====================================================================
	// UART output; RTS stops at byte granularity, well inside the slip
	// no flow on SPI
	assign rts_hold        = cfg_i.rts_enable_setting & rts_sync_reg[1] & uart_side;
	assign uart_tx_valid_o = txq_out_valid & uart_side & ~rts_hold;
	assign uart_tx_data_o  = txq_out_data;
	assign uart_pop        = uart_tx_valid_o & uart_tx_ready_i;
	assign txq_out_ready   = uart_pop | spi_pop;

	a_rts_hold: assert property (rts_hold |-> !uart_tx_valid_o)
		else $error("output sent while RTS high");
	a_spi_no_uart: assert property (spi_side |-> !uart_tx_valid_o && !uart_pop)
		else $error("UART used after SPI took over");

	// =====================================================================
	// status lines: CTS hysteresis, data present, SPI attention
	assign rx_free = `HSP_RXQ_DEPTH - rxq_level;

	always_comb begin
		cts_next    = cts_reg;
		dp_n_next   = 1'b1;
		attn_n_next = ~(spi_side & txq_out_valid);
		if (!cfg_i.cts_enable_setting || !uart_side) begin
			cts_next = 1'b0;
		end else if (rx_free <= `HSP_CTS_STOP_FREE) begin
			cts_next = 1'b1;
		end else if (rx_free >= `HSP_CTS_GO_FREE) begin
			cts_next = 1'b0;
		end
		if (cfg_i.data_present_setting && uart_side && txq_out_valid) begin
			dp_n_next = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cts_reg    <= 1'b0;
			dp_n_reg   <= 1'b1;
			attn_n_reg <= 1'b1;
		end else begin
			cts_reg    <= cts_next;
			dp_n_reg   <= dp_n_next;
			attn_n_reg <= attn_n_next;
		end
	end
	assign cts_pin_o             = cts_reg;
	assign data_present_line_n_o = dp_n_reg;
	assign spi_attn_n_o          = attn_n_reg;

	a_cts_stop: assert property (cfg_i.cts_enable_setting && uart_side
		&& (rx_free <= `HSP_CTS_STOP_FREE) |=> cts_pin_o) else $error("CTS not raised near full");
	a_cts_spi: assert property (spi_side |=> !cts_pin_o)
		else $error("CTS active while SPI selected");
	a_dp_line: assert property (cfg_i.data_present_setting && uart_side && txq_out_valid
		|=> !data_present_line_n_o) else $error("data present line not low");

	// =====================================================================
	// packetization; framed mode and SPI carry frames and never packetize
	// SPI always framed
	assign transparent = uart_side && (cfg_i.frame_mode_setting == `HSP_FRAME_TRANSPARENT);
	assign framed_o    = (sel_reg != hsp_pkg::HSP_SEL_BOOT) & ~transparent;

	always_comb begin
		since_next = since_reg;
		idle_next  = idle_reg;
		pkt_next   = 1'b0;
		if (!transparent) begin
			since_next = 8'h00;
			idle_next  = 8'h00;
		end else begin
			if (uart_push) begin
				since_next = since_reg + 8'h01;
				idle_next  = 8'h00;
				pkt_next   = (packetize_timeout_i == 8'h00);
			end else if (char_tick_i && (since_reg != 8'h00)) begin
				idle_next = idle_reg + 8'h01;
				pkt_next  = (idle_next >= packetize_timeout_i);
			end
			if (cmd_seq_seen_i && (since_reg != 8'h00)) begin
				pkt_next = 1'b1;
			end
			if ((max_payload_count_i != 8'h00) && (since_next >= max_payload_count_i)) begin
				pkt_next = 1'b1;
			end
			if (pkt_next) begin
				since_next = 8'h00;
				idle_next  = 8'h00;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			since_reg <= 8'h00;
			idle_reg  <= 8'h00;
			pkt_reg   <= 1'b0;
		end else begin
			since_reg <= since_next;
			idle_reg  <= idle_next;
			pkt_reg   <= pkt_next;
		end
	end
	assign packetize_o = pkt_reg;

	a_pkt_zero: assert property (transparent && uart_push && (packetize_timeout_i == 8'h00)
		|=> packetize_o) else $error("timeout zero did not packetize");
	a_pkt_cmd: assert property (transparent && cmd_seq_seen_i && (since_reg != 8'h00)
		|=> packetize_o ##1 (since_reg == 8'h00) || $past(uart_push))
		else $error("buffered characters not flushed on command");
	a_pkt_spi: assert property (spi_side |=> !packetize_o && framed_o)
		else $error("SPI port packetized or unframed");

endmodule

// File: tb/hsp_host_model.sv
/*
 * Host processor model acting as SPI master of the steering block.
 * Assumes the bench calls xfer; pins idle deselected through pull-ups.
 */
`timescale 1ns/10ps
module hsp_host_model (
	output hsp_pkg::hsp_spi_pins_s spi_o,
	input  wire logic              miso_i
);
	// =====================================================================
	// pins rest deselected, clock low, data line pulled high
	initial spi_o = '{sclk: 1'h0, mosi: 1'h1, ssel_n: 1'h1};

	// mode 0 byte, select low, one byte per call
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		spi_o.ssel_n = 1'h0;
		for (int i = 7; i >= 0; i--) begin
			spi_o.mosi = tx[i];
			#150 spi_o.sclk = 1'h1;
			rx[i] = miso_i;
			#150 spi_o.sclk = 1'h0;
		end
		// released lines go back to the pull-up level
		#150 spi_o = '{sclk: 1'h0, mosi: 1'h1, ssel_n: 1'h1};
	endtask
endmodule

// File: tb/test_hsp_steer.sv
/*
 * Self-checking bench of hsp_steer: port choice, queues, flow control.
 * Assumes the host model drives the SPI pins; all else is driven here.
 */
`timescale 1ns/10ps
module test_hsp_steer;
	// =====================================================================
	// stimulus, outputs and counters
	logic clk_i, nrst_i, char_tick_i, cmd_seq_seen_i, rts_pin_i, uart_rx_valid_i;
	logic uart_tx_ready_i, rf_rx_valid_i, rf_rx_first_i, rf_tx_ready_i;
	logic uart_tx_valid_o, cts_pin_o, data_present_line_n_o, spi_miso_o, spi_miso_oe_o;
	logic spi_attn_n_o, rf_rx_ready_o, rf_rx_drop_o, rf_tx_valid_o, packetize_o;
	logic framed_o, spi_active_o;
	logic [7:0] packetize_timeout_i, max_payload_count_i, uart_rx_data_i, uart_tx_data_o;
	logic [7:0] rf_rx_len_i, rf_rx_data_i, rf_tx_data_o, got, exp_u;
	hsp_pkg::hsp_cfg_s      cfg_i;
	hsp_pkg::hsp_spi_pins_s spi_pins_i;
	int miscompares, total_checks, pk, dr, up, rn, oe;

	hsp_steer dut (.clk_i, .nrst_i, .cfg_i, .packetize_timeout_i, .max_payload_count_i,
		.char_tick_i, .cmd_seq_seen_i, .uart_rx_valid_i, .uart_rx_data_i, .uart_tx_valid_o,
		.uart_tx_data_o, .uart_tx_ready_i, .rts_pin_i, .cts_pin_o, .data_present_line_n_o,
		.spi_pins_i, .spi_miso_o, .spi_miso_oe_o, .spi_attn_n_o, .rf_rx_valid_i,
		.rf_rx_first_i, .rf_rx_len_i, .rf_rx_data_i, .rf_rx_ready_o, .rf_rx_drop_o,
		.rf_tx_valid_o, .rf_tx_data_o, .rf_tx_ready_i, .packetize_o, .framed_o,
		.spi_active_o);
	hsp_host_model host (.spi_o(spi_pins_i), .miso_i(spi_miso_o));

	initial begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end

	// =====================================================================
	// checking and verdict
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic give_verdict;
		if (miscompares == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// pulses and uart handshakes are counted at the edge that takes them
	always @(posedge clk_i) begin
		if (packetize_o === 1'h1) pk++;
		if (rf_rx_drop_o === 1'h1) dr++;
		if (spi_miso_oe_o === 1'h1) oe++;
		if (uart_tx_valid_o === 1'h1 && uart_tx_ready_i) begin
			chk("uart_tx_data", exp_u, uart_tx_data_o);
			exp_u++;
			up++;
		end
	end

	// =====================================================================
	// access tasks; port enables are read only at boot, so each test resets
	task automatic boot(input logic [1:0] u, input logic [3:0] s);
		cfg_i = '{u, s, 2'h0, 1'h1, 1'h1, 1'h1};
		nrst_i = 1'h0;
		repeat (3) @(posedge clk_i);
		#1 nrst_i = 1'h1;
		repeat (4) @(posedge clk_i);
		#1 {pk, dr, up, oe} = '0;
	endtask

	// valid held across a burst, two idle edges after it
	task automatic push(input int n, input logic [7:0] d0);
		uart_rx_valid_i = 1'h1;
		for (int i = 0; i < n; i++) begin
			uart_rx_data_i = d0 + 8'(i);
			@(posedge clk_i);
			#1;
		end
		uart_rx_valid_i = 1'h0;
		repeat (2) @(posedge clk_i);
		#1;
	endtask

	task automatic rfpkt(input logic [7:0] len, input logic [7:0] d0);
		rf_rx_valid_i = 1'h1;
		rf_rx_len_i = len;
		for (int i = 0; i < len; i++) begin
			rf_rx_first_i = (i == 0);
			rf_rx_data_i = d0 + 8'(i);
			do @(posedge clk_i); while (rf_rx_ready_o !== 1'h1);
			#1;
		end
		rf_rx_valid_i = 1'h0;
		repeat (2) @(posedge clk_i);
		#1;
	endtask

	// a byte seen valid after an edge is taken at the next one
	task automatic drain(input logic [7:0] d0);
		rn = 0;
		rf_tx_ready_i = 1'h1;
		repeat (100) begin
			if (rf_tx_valid_o === 1'h1) begin
				chk("rf_tx_data", d0 + 8'(rn), rf_tx_data_o);
				rn++;
			end
			@(posedge clk_i);
			#1;
		end
		rf_tx_ready_i = 1'h0;
	endtask

	// =====================================================================
	// watchdog, about fifteen hundred cycles are expected
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		give_verdict;
	end

	initial begin
		{nrst_i, char_tick_i, cmd_seq_seen_i, rts_pin_i, uart_rx_valid_i} = '0;
		{uart_tx_ready_i, rf_rx_valid_i, rf_rx_first_i, rf_tx_ready_i} = '0;
		{packetize_timeout_i, max_payload_count_i, uart_rx_data_i} = '0;
		{rf_rx_len_i, rf_rx_data_i, exp_u} = '0;
		cfg_i = '0;
		boot(2'h0, 4'h0);
		chk("data_present", 1, data_present_line_n_o);
		chk("attn_n", 1, spi_attn_n_o);
		push(1, 8'h5a);
		chk("rf_tx_valid", 1, rf_tx_valid_o);
		chk("rf_tx_data", 8'h5a, rf_tx_data_o);
		chk("packetize", 1, pk);
		chk("framed", 0, framed_o);
		boot(2'h3, 4'h0);
		host.xfer(8'h3c, got);
		chk("spi_active", 0, spi_active_o);
		chk("rf_tx_valid", 0, rf_tx_valid_o);
		chk("miso_oe", 0, oe != 0);
		boot(2'h0, 4'hf);
		push(1, 8'h11);
		chk("rf_tx_valid", 0, rf_tx_valid_o);
		chk("spi_active", 1, spi_active_o);
		boot(2'h3, 4'hf);
		uart_tx_ready_i = 1'h1;
		host.xfer(8'ha5, got);
		chk("spi_active", 1, spi_active_o);
		chk("framed", 1, framed_o);
		chk("miso_byte", 8'h00, got);
		push(1, 8'h77);
		rfpkt(8'h2, 8'h30);
		chk("uart_pops", 0, up);
		chk("attn_n", 0, spi_attn_n_o);
		host.xfer(8'ha6, got);
		chk("miso_byte", 8'h30, got);
		host.xfer(8'ha7, got);
		chk("miso_byte", 8'h31, got);
		chk("miso_oe", 1, oe != 0);
		drain(8'ha5);
		chk("rf_tx_pops", 3, rn);
		chk("attn_n", 1, spi_attn_n_o);
		boot(2'h3, 4'h0);
		push(46, 8'h00);
		chk("cts", 0, cts_pin_o);
		push(1, 8'h2e);
		chk("cts", 1, cts_pin_o);
		push(20, 8'h2f);
		drain(8'h00);
		chk("rf_tx_pops", 64, rn);
		chk("cts", 0, cts_pin_o);
		packetize_timeout_i = 8'hff;
		max_payload_count_i = 8'h04;
		boot(2'h3, 4'h0);
		push(3, 8'h40);
		chk("packetize", 0, pk);
		push(1, 8'h43);
		chk("packetize", 1, pk);
		// the flush needs characters buffered ahead of the sequence
		push(2, 8'h44);
		cmd_seq_seen_i = 1'h1;
		@(posedge clk_i);
		#1 cmd_seq_seen_i = 1'h0;
		repeat (2) @(posedge clk_i);
		#1 chk("packetize", 2, pk);
		packetize_timeout_i = 8'h02;
		push(1, 8'h46);
		char_tick_i = 1'h1;
		repeat (2) @(posedge clk_i);
		#1 char_tick_i = 1'h0;
		repeat (2) @(posedge clk_i);
		#1 chk("packetize", 3, pk);
		exp_u = 8'h10;
		uart_tx_ready_i = 1'h0;
		boot(2'h3, 4'h0);
		rfpkt(8'h8, 8'h10);
		chk("data_present", 0, data_present_line_n_o);
		rfpkt(8'h9, 8'h20);
		chk("drops", 1, dr);
		rts_pin_i = 1'h1;
		repeat (4) @(posedge clk_i);
		#1 uart_tx_ready_i = 1'h1;
		repeat (20) @(posedge clk_i);
		#1 chk("uart_pops", 0, up);
		rts_pin_i = 1'h0;
		repeat (4) @(posedge clk_i);
		#1 rts_pin_i = 1'h1;
		repeat (20) @(posedge clk_i);
		#1 chk("rts_slip", 1, up <= 5);
		chk("rts_resume", 1, up != 0);
		rts_pin_i = 1'h0;
		repeat (30) @(posedge clk_i);
		#1 chk("uart_pops", 8, up);
		chk("data_present", 1, data_present_line_n_o);
		give_verdict;
	end
endmodule
